// ---- src/adcpk_pkg.sv ----
// How it works
// [RL1] lost result sets flag; control read clears
// [RL2] width code 0 gives 8-bit; 2 reserved
// [RL3] code 1: result, four zeros, MSB first
// [RL4] code 3: result, twenty zeros, MSB first
// [RL5] samples per packet field, resets to one
// [RL6] zero count: end on register access or destination change
// [RL7] calibration bit selects internal reference
// [RL8] software discards one sample after switching
// [RL9] enable bit zero, resets disabled
// [RL10] pin registers read-only while enabled
// [RL11] software programs pins while disabled
// [RL12] first six triggers calibrate, no packets
// [RL13] seventh trigger onward delivers samples
// [RL14] calibration restarts on every enable edge
// [RL15] each rising trigger edge converts next pin; an edge while a conversion is busy is lost
// [RL16] pin register: enable bit, 24-bit destination
// [RL17] enabled pins ascending, wrap; none skips
// [RL18] drop when result meets full buffer
package adcpk_pkg;
   localparam int NPIN = 4;
   localparam logic [7:0] ADDR_PIN0 = 8'h00;
   localparam logic [7:0] ADDR_PIN_LAST = 8'h0C;
   localparam logic [7:0] ADDR_GCTL = 8'h20;
   localparam int GC_EN = 0;
   localparam int GC_CAL = 1;
   localparam int GC_SPP_LO = 8;
   localparam int GC_WID_LO = 16;
   localparam int GC_DROP = 24;
   localparam int PIN_EN = 0;
   localparam int PIN_DEST_LO = 8;
   localparam logic [1:0] RST_WID = 2'h1;
   localparam logic [7:0] RST_SPP = 8'h01;
   localparam logic RST_DROP = 1'b1;
   localparam logic [1:0] RST_PIN = 2'h3;
   localparam logic [2:0] CAL_PULSES = 3'h6;
   localparam int ENTRY_W = 58;
   typedef enum logic [1:0] {
      ADCPK_W8 = 2'b00,
      ADCPK_W16 = 2'b01,
      ADCPK_WRSV = 2'b10,
      ADCPK_W32 = 2'b11
   } adcpk_wid_t;
   typedef enum logic [1:0] {
      ADCPK_IDLE = 2'b00,
      ADCPK_BYTES = 2'b01,
      ADCPK_END = 2'b10
   } adcpk_tx_t;
endpackage

// ---- src/adcpk_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcpk_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // pin in, synchronised out
   input wire logic din,
   output logic dout
);
   logic meta;
   logic next_meta;
   logic next_dout;

   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else if (ce) begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule
`default_nettype wire

// ---- src/adcpk_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcpk_buf #(
   parameter int W = adcpk_pkg::ENTRY_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem [2];
   logic [W-1:0] next_mem [2];
   logic wp, rp, next_wp, next_rp;
   logic [1:0] cnt, next_cnt;
   logic push, pop;

   assign in_ready = (cnt != 2'h2);
   assign out_valid = (cnt != 2'h0);
   assign out_data = mem[rp];

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_mem = mem;
      next_wp = wp;
      next_rp = rp;
      if (push) begin
         next_mem[wp] = in_data;
         next_wp = ~wp;
      end
      if (pop) begin
         next_rp = ~rp;
      end
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
   end

   // data words carry no reset: only pointers and count matter
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'h0;
      end else if (ce) begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge mclk) begin
      if (ce) begin
         mem <= next_mem;
      end
   end
endmodule
`default_nettype wire

// ---- src/adcpk_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcpk_ctrl (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // trigger pin
   input wire logic adc_trig,
   // converter core
   output logic conv_start,
   output logic [1:0] conv_chan,
   output logic conv_ref_sel,
   input wire logic conv_done,
   input wire logic [11:0] conv_result,
   // message endpoint
   output logic ep_valid,
   input wire logic ep_ready,
   output logic [7:0] ep_data,
   output logic [23:0] ep_dest,
   output logic ep_end
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic is_pin(input logic [7:0] a);
      is_pin = (a <= adcpk_pkg::ADDR_PIN_LAST) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [31:0] fmt(input logic [1:0] w, input logic [11:0] r);
      case (w)
         adcpk_pkg::ADCPK_W8: fmt = {r[11:4], 24'h000000}; // [RL2]
         adcpk_pkg::ADCPK_W32: fmt = {r, 20'h00000}; // [RL4]
         default: fmt = {r, 4'h0, 16'h0000}; // [RL3]
      endcase
   endfunction

   // reserved code is sent as 16-bit rather than dropped
   function automatic logic [2:0] nbytes(input logic [1:0] w);
      case (w)
         adcpk_pkg::ADCPK_W8: nbytes = 3'h1; // [RL2]
         adcpk_pkg::ADCPK_W32: nbytes = 3'h4; // [RL4]
         default: nbytes = 3'h2; // [RL3]
      endcase
   endfunction

   // next enabled pin above last, wrapping; msb says one was found
   function automatic logic [2:0] next_pin(input logic [3:0] en, input logic [1:0] last);
      logic [1:0] idx;
      next_pin = 3'h0;
      for (int k = 4; k >= 1; k--) begin
         idx = last + 2'(k);
         if (en[idx]) begin
            next_pin = {1'b1, idx}; // [RL17]
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic trig_s, trig_d, trig_edge;
   logic [3:0] pin_en, next_pin_en;
   logic [23:0] pin_dest [4];
   logic [23:0] next_pin_dest [4];
   logic gc_en, gc_cal, gc_drop, next_gc_en, next_gc_cal, next_gc_drop;
   logic [7:0] gc_spp, next_gc_spp;
   logic [1:0] gc_wid, next_gc_wid;
   logic [2:0] cal_cnt, next_cal_cnt;
   logic [31:0] next_rdata;
   logic wr_gc, rd_gc, drop_ev;
   logic busy, next_busy, cur_cal, next_cur_cal, go, keep_res;
   logic [1:0] next_chan;
   logic [2:0] pick;
   logic buf_in_ready, buf_out_valid, buf_out_ready;
   logic [adcpk_pkg::ENTRY_W-1:0] buf_in_data, buf_out_data;
   adcpk_pkg::adcpk_tx_t st, next_st;
   logic [31:0] sh_word, next_sh_word;
   logic [2:0] bytes_left, next_bytes_left;
   logic [7:0] samp_cnt, next_samp_cnt;
   logic pkt_open, next_pkt_open, term_req, next_term_req;
   logic [23:0] next_ep_dest;
   logic acc;

   adcpk_sync u_trig_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .din(adc_trig),
      .dout(trig_s)
   );

   assign trig_edge = trig_s && !trig_d; // [RL15]

   ////////////////////////////////////////////////////////////////////////////////
   // register file
   always_comb begin
      wr_gc = reg_wr && (reg_addr == adcpk_pkg::ADDR_GCTL);
      rd_gc = reg_rd && (reg_addr == adcpk_pkg::ADDR_GCTL);
      next_pin_en = pin_en;
      next_pin_dest = pin_dest;
      next_gc_en = gc_en;
      next_gc_cal = gc_cal;
      next_gc_spp = gc_spp;
      next_gc_wid = gc_wid;
      next_cal_cnt = cal_cnt;
      // reprogramming while running would retarget live samples
      if (reg_wr && is_pin(reg_addr) && !gc_en) begin // [RL10]
         next_pin_en[reg_addr[3:2]] = reg_wdata[adcpk_pkg::PIN_EN]; // [RL16]
         next_pin_dest[reg_addr[3:2]] = reg_wdata[31:adcpk_pkg::PIN_DEST_LO]; // [RL16]
      end
      if (wr_gc) begin
         next_gc_en = reg_wdata[adcpk_pkg::GC_EN]; // [RL9]
         next_gc_cal = reg_wdata[adcpk_pkg::GC_CAL]; // [RL7]
         next_gc_spp = reg_wdata[adcpk_pkg::GC_SPP_LO +: 8]; // [RL5]
         next_gc_wid = reg_wdata[adcpk_pkg::GC_WID_LO +: 2]; // [RL2]
      end
      if (wr_gc && reg_wdata[adcpk_pkg::GC_EN] && !gc_en) begin
         next_cal_cnt = adcpk_pkg::CAL_PULSES; // [RL14]
      end else if (trig_edge && gc_en && (cal_cnt != 3'h0)) begin
         next_cal_cnt = cal_cnt - 3'h1; // [RL12]
      end
      next_gc_drop = (gc_drop && !rd_gc) || drop_ev; // [RL1]
      next_rdata = 32'h00000000;
      if (reg_rd) begin
         if (is_pin(reg_addr)) begin
            next_rdata = {pin_dest[reg_addr[3:2]], 7'h00, pin_en[reg_addr[3:2]]};
         end else if (rd_gc) begin
            next_rdata = {7'h00, gc_drop, 6'h00, gc_wid, gc_spp, 6'h00, gc_cal, gc_en};
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_en <= 4'h0;
         pin_dest <= '{default: 24'h000000};
         gc_en <= 1'b0;
         gc_cal <= 1'b0;
         gc_spp <= adcpk_pkg::RST_SPP;
         gc_wid <= adcpk_pkg::RST_WID;
         gc_drop <= adcpk_pkg::RST_DROP;
         cal_cnt <= 3'h0;
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         pin_en <= next_pin_en;
         pin_dest <= next_pin_dest;
         gc_en <= next_gc_en;
         gc_cal <= next_gc_cal;
         gc_spp <= next_gc_spp;
         gc_wid <= next_gc_wid;
         gc_drop <= next_gc_drop;
         cal_cnt <= next_cal_cnt;
         reg_rdata <= next_rdata;
      end
   end

   assign conv_ref_sel = gc_cal; // [RL7]

   ////////////////////////////////////////////////////////////////////////////////
   // conversion sequencing; a trigger during a busy conversion is lost
   always_comb begin
      pick = next_pin(pin_en, conv_chan);
      go = gc_en && trig_edge && pick[2] && !busy; // [RL15] [RL17]
      next_busy = busy;
      next_chan = conv_chan;
      next_cur_cal = cur_cal;
      if (go) begin
         next_busy = 1'b1;
         next_chan = pick[1:0];
         next_cur_cal = (cal_cnt != 3'h0); // [RL12]
      end else if (conv_done) begin
         next_busy = 1'b0;
      end
      keep_res = conv_done && busy && !cur_cal; // [RL13]
      drop_ev = keep_res && !buf_in_ready; // [RL18]
      buf_in_data = {pin_dest[conv_chan], gc_wid, fmt(gc_wid, conv_result)};
   end

   assign conv_start = ce && go;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_d <= 1'b0;
         busy <= 1'b0;
         cur_cal <= 1'b0;
         conv_chan <= adcpk_pkg::RST_PIN;
      end else if (ce) begin
         trig_d <= trig_s;
         busy <= next_busy;
         cur_cal <= next_cur_cal;
         conv_chan <= next_chan;
      end
   end

   adcpk_buf #(
      .W(adcpk_pkg::ENTRY_W)
   ) u_buf (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .in_valid(keep_res),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // packet transmitter
   assign ep_valid = (st != adcpk_pkg::ADCPK_IDLE);
   assign ep_end = (st == adcpk_pkg::ADCPK_END);
   assign ep_data = sh_word[31:24];
   assign buf_out_ready = (st == adcpk_pkg::ADCPK_IDLE) && !(term_req && pkt_open)
      && !(pkt_open && (buf_out_data[57:34] != ep_dest));

   always_comb begin
      acc = (reg_wr || reg_rd) && (is_pin(reg_addr) || (reg_addr == adcpk_pkg::ADDR_GCTL));
      next_st = st;
      next_sh_word = sh_word;
      next_bytes_left = bytes_left;
      next_samp_cnt = samp_cnt;
      next_pkt_open = pkt_open;
      next_ep_dest = ep_dest;
      next_term_req = term_req || (acc && (gc_spp == 8'h00) && pkt_open); // [RL6]
      case (st)
         adcpk_pkg::ADCPK_IDLE: begin
            if (term_req && pkt_open) begin
               next_st = adcpk_pkg::ADCPK_END; // [RL6]
            end else if (buf_out_valid && pkt_open && (buf_out_data[57:34] != ep_dest)) begin
               next_st = adcpk_pkg::ADCPK_END;
            end else if (buf_out_valid) begin
               next_sh_word = buf_out_data[31:0];
               next_bytes_left = nbytes(buf_out_data[33:32]);
               next_ep_dest = buf_out_data[57:34];
               next_pkt_open = 1'b1;
               next_st = adcpk_pkg::ADCPK_BYTES;
            end
         end
         adcpk_pkg::ADCPK_BYTES: begin
            if (ep_ready) begin
               next_sh_word = {sh_word[23:0], 8'h00}; // [RL3] [RL4]
               next_bytes_left = bytes_left - 3'h1;
               if (bytes_left == 3'h1) begin
                  next_samp_cnt = samp_cnt + 8'h01;
                  if ((gc_spp != 8'h00) && (samp_cnt + 8'h01 >= gc_spp)) begin
                     next_st = adcpk_pkg::ADCPK_END; // [RL5]
                  end else begin
                     next_st = adcpk_pkg::ADCPK_IDLE;
                  end
               end
            end
         end
         adcpk_pkg::ADCPK_END: begin
            if (ep_ready) begin
               next_st = adcpk_pkg::ADCPK_IDLE;
               next_pkt_open = 1'b0;
               next_samp_cnt = 8'h00;
               next_term_req = 1'b0;
            end
         end
         default: begin
            next_st = adcpk_pkg::ADCPK_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= adcpk_pkg::ADCPK_IDLE;
         sh_word <= 32'h00000000;
         bytes_left <= 3'h0;
         samp_cnt <= 8'h00;
         pkt_open <= 1'b0;
         term_req <= 1'b0;
         ep_dest <= 24'h000000;
      end else if (ce) begin
         st <= next_st;
         sh_word <= next_sh_word;
         bytes_left <= next_bytes_left;
         samp_cnt <= next_samp_cnt;
         pkt_open <= next_pkt_open;
         term_req <= next_term_req;
         ep_dest <= next_ep_dest;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_last_byte;
      ce && (st == adcpk_pkg::ADCPK_BYTES) && ep_ready && (bytes_left == 3'h1);
   endsequence

   sequence s_full_count;
      (gc_spp != 8'h00) && (samp_cnt + 8'h01 >= gc_spp);
   endsequence

   property p_drop_set;
      @(posedge mclk) disable iff (sys_rst)
         ce && conv_done && busy && !cur_cal && !buf_in_ready |=> gc_drop;
   endproperty
   a_drop_set: assert property (p_drop_set) else $error("lost sample not flagged"); // [RL18]

   property p_drop_clr;
      @(posedge mclk) disable iff (sys_rst)
         ce && rd_gc && !drop_ev |=> !gc_drop && (reg_rdata[adcpk_pkg::GC_DROP] == $past(gc_drop));
   endproperty
   a_drop_clr: assert property (p_drop_clr) else $error("drop flag not cleared by read"); // [RL1]

   property p_pin_ro;
      @(posedge mclk) disable iff (sys_rst)
         ce && gc_en && reg_wr && is_pin(reg_addr) |=> $stable(pin_en) && $stable(pin_dest[0])
         && $stable(pin_dest[1]) && $stable(pin_dest[2]) && $stable(pin_dest[3]);
   endproperty
   a_pin_ro: assert property (p_pin_ro) else $error("pin register changed while enabled"); // [RL10]

   property p_cal_restart;
      @(posedge mclk) disable iff (sys_rst)
         ce && wr_gc && reg_wdata[adcpk_pkg::GC_EN] && !gc_en
         |=> gc_en && (cal_cnt == adcpk_pkg::CAL_PULSES);
   endproperty
   a_cal_restart: assert property (p_cal_restart) else $error("calibration not restarted"); // [RL14]

   property p_cal_silent;
      @(posedge mclk) disable iff (sys_rst)
         conv_done && busy && cur_cal |-> !keep_res;
   endproperty
   a_cal_silent: assert property (p_cal_silent) else $error("calibration sample queued"); // [RL12]

   property p_start_pin;
      @(posedge mclk) disable iff (sys_rst)
         conv_start |-> gc_en && pin_en[pick[1:0]] && trig_s && !trig_d ##1 busy;
   endproperty
   a_start_pin: assert property (p_start_pin) else $error("conversion without cause"); // [RL17]

   property p_spp_end;
      @(posedge mclk) disable iff (sys_rst)
         s_last_byte and s_full_count |=> ep_end && ep_valid;
   endproperty
   a_spp_end: assert property (p_spp_end) else $error("packet not ended at count"); // [RL5]

   property p_open_hold;
      @(posedge mclk) disable iff (sys_rst)
         s_last_byte and (gc_spp == 8'h00) |=> !ep_end;
   endproperty
   a_open_hold: assert property (p_open_hold) else $error("open packet ended early"); // [RL6]

   property p_w8_one;
      @(posedge mclk) disable iff (sys_rst)
         ce && buf_out_valid && buf_out_ready && (buf_out_data[33:32] == 2'b00)
         |=> (bytes_left == 3'h1) && (ep_data == $past(buf_out_data[31:24]));
   endproperty
   a_w8_one: assert property (p_w8_one) else $error("8-bit sample length wrong"); // [RL2]

   property p_ref;
      @(posedge mclk) disable iff (sys_rst)
         ce && wr_gc |=> conv_ref_sel == $past(reg_wdata[adcpk_pkg::GC_CAL]);
   endproperty
   a_ref: assert property (p_ref) else $error("reference select not following bit"); // [RL7]
endmodule
`default_nettype wire

// ---- dv/adcpk_far.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcpk_far (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // converter core
   input wire logic conv_start,
   input wire logic [1:0] conv_chan,
   input wire logic conv_ref_sel,
   output logic conv_done,
   output logic [11:0] conv_result,
   // message endpoint
   input wire logic ep_valid,
   output logic ep_ready,
   input wire logic [7:0] ep_data,
   input wire logic [23:0] ep_dest,
   input wire logic ep_end,
   // stall mode: 0 ready, 1 stalled, 2 every other cycle
   input wire logic [1:0] mode
);
   logic [32:0] q[$];
   logic [2:0] busy_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // pin number sits in the top result bits so width truncation shows it
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt <= 3'h0;
         conv_done <= 1'b0;
         conv_result <= 12'h000;
         ep_ready <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         // no stale result: bus flips while idle
         conv_result <= ~conv_result;
         if (conv_start)
            busy_cnt <= 3'h4;
         else if (busy_cnt != 3'h0)
            busy_cnt <= busy_cnt - 3'h1;
         if (busy_cnt == 3'h1) begin
            conv_done <= 1'b1;
            conv_result <= conv_ref_sel ? 12'h3E8 : {conv_chan, 10'h1A5};
         end
         ep_ready <= (mode == 2'h0) | ((mode == 2'h2) & ~ep_ready);
         if (ep_valid & ep_ready)
            q.push_back({ep_end, ep_dest, ep_end ? 8'h00 : ep_data});
      end
   end
endmodule
`default_nettype wire

// ---- dv/adc_sample_packetizer_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sample_packetizer_control_tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h00000000;
   logic [31:0] reg_rdata;
   logic adc_trig = 1'b0;
   logic conv_start;
   logic [1:0] conv_chan;
   logic conv_ref_sel;
   logic conv_done;
   logic [11:0] conv_result;
   logic ep_valid;
   logic ep_ready;
   logic [7:0] ep_data;
   logic [23:0] ep_dest;
   logic ep_end;
   logic ce = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [1:0] p = 2'h0;
   logic [1:0] wl [3] = '{2'h0, 2'h2, 2'h3};
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   localparam logic [23:0] D0 = 24'hABCDE1;
   localparam logic [23:0] D2 = 24'h123456;
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   adcpk_ctrl u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_trig(adc_trig),
      .conv_start(conv_start), .conv_chan(conv_chan), .conv_ref_sel(conv_ref_sel),
      .conv_done(conv_done), .conv_result(conv_result), .ep_valid(ep_valid),
      .ep_ready(ep_ready), .ep_data(ep_data), .ep_dest(ep_dest), .ep_end(ep_end)
   );
   adcpk_far u_far (
      .mclk(mclk), .sys_rst(sys_rst), .conv_start(conv_start), .conv_chan(conv_chan),
      .conv_ref_sel(conv_ref_sel), .conv_done(conv_done), .conv_result(conv_result),
      .ep_valid(ep_valid), .ep_ready(ep_ready), .ep_data(ep_data), .ep_dest(ep_dest),
      .ep_end(ep_end), .mode(mode)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [32:0] s, input logic [32:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   // extra idle cycle keeps strobes from being reassigned in one time step
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk) #1;
      reg_wr = 1'b0;
      @(posedge mclk) #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk) #1;
      reg_rd = 1'b0;
      check({1'b0, reg_rdata}, {1'b0, e});
      @(posedge mclk) #1;
   endtask
   // each pulse is long enough for the synchroniser, then the packet drains
   task automatic trig(input int n);
      repeat (n) begin
         adc_trig = 1'b1;
         repeat (3) @(posedge mclk) #1;
         adc_trig = 1'b0;
         repeat (40) @(posedge mclk) #1;
      end
   endtask
   task automatic tok(input logic en, input logic [23:0] dst, input logic [7:0] d);
      if (u_far.q.size() == 0)
         check({33{1'bx}}, {en, dst, d});
      else
         check(u_far.q.pop_front(), {en, dst, d});
   endtask
   task automatic samp(input logic [1:0] pin, input logic [1:0] w, input logic cal,
         input logic endp);
      logic [23:0] dst;
      logic [31:0] word;
      dst = (pin == 2'h0) ? D0 : D2;
      word = {(cal ? 12'h3E8 : {pin, 10'h1A5}), 20'h00000};
      tok(1'b0, dst, word[31:24]);
      if (w != adcpk_pkg::ADCPK_W8)
         tok(1'b0, dst, word[23:16]);
      if (w == adcpk_pkg::ADCPK_W32) begin
         tok(1'b0, dst, word[15:8]);
         tok(1'b0, dst, word[7:0]);
      end
      if (endp)
         tok(1'b1, dst, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      @(posedge mclk) #1;
      rd_chk(8'h20, 32'h01010100);
      rd_chk(8'h20, 32'h00010100);
      rd_chk(8'h00, 32'h00000000);
      rd_chk(8'h10, 32'h00000000);
      wr_reg(8'h00, {D0, 8'h01});
      wr_reg(8'h08, {D2, 8'h01});
      rd_chk(8'h00, {D0, 8'h01});
      mode = 2'h2;
      wr_reg(8'h20, 32'h00010101);
      wr_reg(8'h04, 32'hFFFFFF01);
      rd_chk(8'h04, 32'h00000000);
      trig(6);
      check(33'(u_far.q.size()), 33'h0);
      trig(1);
      samp(2'h0, 2'h1, 1'b0, 1'b1);
      trig(1);
      samp(2'h2, 2'h1, 1'b0, 1'b1);
      trig(1);
      samp(2'h0, 2'h1, 1'b0, 1'b1);
      p = 2'h2;
      for (int i = 0; i < 3; i++) begin
         wr_reg(8'h20, {14'h0000, wl[i], 16'h0101});
         trig(1);
         samp(p, wl[i], 1'b0, 1'b1);
         p = p ^ 2'h2;
      end
      wr_reg(8'h20, 32'h00030103);
      check({32'h0, conv_ref_sel}, 33'h1);
      trig(1);
      u_far.q.delete();
      trig(1);
      samp(2'h2, 2'h3, 1'b1, 1'b1);
      wr_reg(8'h20, 32'h00030101);
      check({32'h0, conv_ref_sel}, 33'h0);
      trig(1);
      u_far.q.delete();
      // only pin 0 stays enabled, so no destination change closes packets
      wr_reg(8'h20, 32'h00000100);
      wr_reg(8'h08, 32'h00000000);
      wr_reg(8'h20, 32'h00000201);
      trig(6);
      check(33'(u_far.q.size()), 33'h0);
      trig(2);
      samp(2'h0, 2'h0, 1'b0, 1'b0);
      samp(2'h0, 2'h0, 1'b0, 1'b1);
      wr_reg(8'h20, 32'h00000001);
      trig(2);
      samp(2'h0, 2'h0, 1'b0, 1'b0);
      samp(2'h0, 2'h0, 1'b0, 1'b0);
      check(33'(u_far.q.size()), 33'h0);
      rd_chk(8'h20, 32'h00000001);
      repeat (10) @(posedge mclk) #1;
      tok(1'b1, D0, 8'h00);
      wr_reg(8'h20, 32'h00000101);
      mode = 2'h1;
      trig(5);
      rd_chk(8'h20, 32'h01000101);
      mode = 2'h0;
      repeat (30) @(posedge mclk) #1;
      samp(2'h0, 2'h0, 1'b0, 1'b1);
      u_far.q.delete();
      rd_chk(8'h20, 32'h00000101);
      // frozen clock enable: a write must not land
      ce = 1'b0;
      wr_reg(8'h20, 32'h00000000);
      ce = 1'b1;
      rd_chk(8'h20, 32'h00000101);
      final_report();
   end
endmodule
`default_nettype wire
